// ==== src/csg_pkg.sv ====
// Package for the service gate and self-test supervisor.
// Assumes one 100 MHz clock domain and an AXI4-Lite register bus.
package csg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_RESULT   = 8'h08;
  localparam logic [7:0] REG_OPERATOR = 8'h0C;
  localparam logic [7:0] REG_CONFIG   = 8'h10;
  localparam logic [7:0] REG_DIGEST   = 8'h14;
  localparam logic [7:0] REG_KEYSTATE = 8'h18;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int CMD_SVC_LSB  = 0;
  localparam int CMD_ARG_LSB  = 8;
  localparam int CMD_NEG_BIT  = 16;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int ST_LOADER_LSB = 0;
  localparam int ST_CAP_LSB    = 2;
  localparam int ST_ENGINE_LSB = 4;
  localparam int ST_ROLE_LSB   = 12;
  localparam int ST_FATAL_BIT  = 14;
  localparam int ST_BUSY_BIT   = 15;
  localparam int ST_DIAG_BIT   = 16;
  localparam int ST_OUTEN_BIT  = 17;
  localparam int ST_READY_BIT  = 18;

  localparam logic [1:0] LOADER_OK   = 2'h1;
  localparam logic [1:0] LOADER_FAIL = 2'h2;
  localparam logic [1:0] CAP_OK      = 2'h2;
  localparam logic [1:0] CAP_FAIL    = 2'h1;
  localparam logic [7:0] ENG_AES     = 8'h01;
  localparam logic [7:0] ENG_SHA     = 8'h02;
  localparam logic [7:0] ENG_KW      = 8'h08;
  localparam logic [7:0] ENG_XTS     = 8'h04;

  // ----------------------------------------------------------------
  // Result codes
  // ----------------------------------------------------------------
  localparam logic [31:0] RES_OK        = 32'h0000_0000;
  localparam logic [31:0] RES_DENIED    = 32'h0000_0001;
  localparam logic [31:0] RES_BAD_CMD   = 32'h0000_0002;
  localparam logic [31:0] RES_LOGGED_IN = 32'h0000_0003;
  localparam logic [31:0] RES_AUTH_FAIL = 32'h0000_0004;
  localparam logic [31:0] RES_BUSY      = 32'h0000_0005;
  localparam logic [31:0] RES_DIAG_FAIL = 32'h0000_0006;
  localparam logic [31:0] RES_FW_HMAC   = 32'h0000_000E;

  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ROLE_NONE, ROLE_OFFICER, ROLE_USER} csg_role_e;

  typedef enum logic [7:0] {
    SVC_CONFIGURE   = 8'h01,
    SVC_DIAG_TEST   = 8'h02,
    SVC_ENCRYPT     = 8'h03,
    SVC_DECRYPT     = 8'h04,
    SVC_OP_ADD      = 8'h05,
    SVC_OP_KEY_UPD  = 8'h06,
    SVC_OP_ZERO_ONE = 8'h07,
    SVC_OP_ZERO_ALL = 8'h08,
    SVC_DEK_UPDATE  = 8'h09,
    SVC_DEK_ZERO    = 8'h0A,
    SVC_KEK_UPDATE  = 8'h0B,
    SVC_KEK_ZERO    = 8'h0C,
    SVC_HMAC_SET    = 8'h0D,
    SVC_HMAC_ZERO   = 8'h0E,
    SVC_FW_UPDATE   = 8'h0F,
    SVC_RESET       = 8'h10,
    SVC_LOGIN       = 8'h11,
    SVC_LOGOUT      = 8'h12,
    SVC_GET_OP      = 8'h13,
    SVC_GET_CONFIG  = 8'h14,
    SVC_SHOW_STATUS = 8'h15
  } csg_svc_e;

  typedef enum logic [2:0] {
    ST_CRC, ST_KAT, ST_IDLE, ST_SERVICE, ST_ZEROIZE, ST_FATAL
  } csg_state_e;

  typedef struct packed {
    logic        pass;
    logic [7:0]  fail_engine;
  } csg_kat_s;

  // Engine handshake towards crypto cores (datapaths are outside)
  typedef struct packed {
    logic        req;
    logic [7:0]  svc;
    logic        negative;
  } csg_eng_req_s;

  typedef struct packed {
    logic        done;
    logic        match;
    logic [31:0] digest;
  } csg_eng_rsp_s;

endpackage : csg_pkg

// ==== src/csg_gate.sv ====
// Service gate and self-test supervisor: role checks, power-up tests,
// firmware authentication result and diagnostics, AXI4-Lite registers.
// Assumes the crypto engines, flash CRC and certificate unwrap sit outside
// and answer through done/match handshakes.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module csg_gate #(
  parameter int KAT_COUNT = 4
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Flash CRC checker
  output logic                      crc_start,
  input  wire logic                 crc_done,
  input  wire logic                 crc_ok,
  // Crypto engines (known-answer, HMAC, login unwrap, key unwrap)
  output csg_pkg::csg_eng_req_s     eng_req,
  input  wire csg_pkg::csg_eng_rsp_s eng_rsp,
  input  wire logic [1:0]           login_role,
  input  wire logic                 io_message_block_active,
  // Key store zeroize strobes with fill pattern
  output logic [3:0]                key_zero,
  output logic [7:0]                key_zero_fill,
  output logic                      data_out_enable,
  output logic [3:0]                status_led
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    csg_pkg::csg_state_e st;
    csg_pkg::csg_role_e  role;
    logic [1:0]          loader;
    logic [1:0]          cap;
    logic [7:0]          engine;
    logic [2:0]          kat_idx;
    logic                diag_mode;
    logic                busy;
    logic [7:0]          svc;
    logic                neg;
    logic [31:0]         result;
    logic [31:0]         digest;
    logic [31:0]         config_word;
    logic [3:0]          key_valid;
    logic [3:0]          zero;
    logic                aw_got;
    logic                w_got;
    logic [7:0]          awaddr;
    logic [31:0]         wdata;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic                req;
    logic                crc_go;
  } csg_state_s;

  csg_state_s s_r;
  csg_state_s s_nxt;

  logic fire_w;
  logic [7:0] cmd_svc;

  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign fire_w        = (s_r.aw_got || (s_axi_awvalid && s_axi_awready))
                      && (s_r.w_got || (s_axi_wvalid && s_axi_wready));

  // ----------------------------------------------------------------
  // Role gate
  // ----------------------------------------------------------------
  function automatic logic role_ok(input logic [7:0] svc, input csg_pkg::csg_role_e role);
    logic ok;
    ok = 1'b0;
    case (svc)
      csg_pkg::SVC_CONFIGURE, csg_pkg::SVC_DIAG_TEST:
        ok = (role == csg_pkg::ROLE_OFFICER);
      csg_pkg::SVC_ENCRYPT, csg_pkg::SVC_DECRYPT:
        ok = (role == csg_pkg::ROLE_USER);
      csg_pkg::SVC_OP_ADD, csg_pkg::SVC_OP_KEY_UPD, csg_pkg::SVC_OP_ZERO_ONE, csg_pkg::SVC_OP_ZERO_ALL:
        ok = (role != csg_pkg::ROLE_NONE);
      csg_pkg::SVC_DEK_UPDATE, csg_pkg::SVC_DEK_ZERO, csg_pkg::SVC_KEK_UPDATE, csg_pkg::SVC_KEK_ZERO,
      csg_pkg::SVC_HMAC_SET, csg_pkg::SVC_HMAC_ZERO, csg_pkg::SVC_FW_UPDATE:
        ok = (role != csg_pkg::ROLE_NONE);
      csg_pkg::SVC_RESET, csg_pkg::SVC_LOGIN, csg_pkg::SVC_LOGOUT, csg_pkg::SVC_GET_OP,
      csg_pkg::SVC_GET_CONFIG, csg_pkg::SVC_SHOW_STATUS:
        ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : role_ok

  function automatic logic [31:0] status_word(input csg_state_s s);
    logic [31:0] w;
    w = '0;
    w[csg_pkg::ST_LOADER_LSB +: 2] = s.loader;
    w[csg_pkg::ST_CAP_LSB +: 2]    = s.cap;
    w[csg_pkg::ST_ENGINE_LSB +: 8] = s.engine;
    w[csg_pkg::ST_ROLE_LSB +: 2]   = s.role;
    w[csg_pkg::ST_FATAL_BIT]       = (s.st == csg_pkg::ST_FATAL);
    w[csg_pkg::ST_BUSY_BIT]        = s.busy;
    w[csg_pkg::ST_DIAG_BIT]        = s.diag_mode;
    w[csg_pkg::ST_OUTEN_BIT]       = (s.st == csg_pkg::ST_IDLE || s.st == csg_pkg::ST_SERVICE);
    w[csg_pkg::ST_READY_BIT]       = (s.st == csg_pkg::ST_IDLE);
    return w;
  endfunction : status_word

  assign cmd_svc = s_r.w_got ? s_r.wdata[csg_pkg::CMD_SVC_LSB +: 8] : s_axi_wdata[csg_pkg::CMD_SVC_LSB +: 8];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]  a;
    logic [31:0] d;
    logic        pass;
    a = s_r.aw_got ? s_r.awaddr : s_axi_awaddr;
    d = s_r.w_got ? s_r.wdata : s_axi_wdata;
    pass = 1'b0;
    s_nxt = s_r;
    s_nxt.zero = '0;
    s_nxt.req = 1'b0;
    s_nxt.crc_go = 1'b0;

    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Engine state machine
    case (s_r.st)
      csg_pkg::ST_CRC: begin
        s_nxt.busy = 1'b1;
        if (crc_done) begin
          if (crc_ok) begin
            s_nxt.loader  = csg_pkg::LOADER_OK;
            s_nxt.st      = csg_pkg::ST_KAT;
            s_nxt.kat_idx = '0;
            s_nxt.req     = 1'b1;
          end else begin
            s_nxt.loader = csg_pkg::LOADER_FAIL;
            s_nxt.st     = csg_pkg::ST_FATAL;
          end
        end
      end
      csg_pkg::ST_KAT: begin
        // Fixed list: AES ECB, HMAC SHA-256, XTS, key wrap
        if (eng_rsp.done) begin
          if (!eng_rsp.match) begin
            s_nxt.cap    = csg_pkg::CAP_FAIL;
            s_nxt.engine = csg_pkg::ENG_AES << s_r.kat_idx;
            s_nxt.st     = csg_pkg::ST_FATAL;
          end else if (s_r.kat_idx == 3'(KAT_COUNT - 1)) begin
            s_nxt.cap  = csg_pkg::CAP_OK;
            s_nxt.st   = csg_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
          end else begin
            s_nxt.kat_idx = s_r.kat_idx + 3'h1;
            s_nxt.req     = 1'b1;
          end
        end
      end
      csg_pkg::ST_SERVICE: begin
        if (eng_rsp.done) begin
          s_nxt.busy = 1'b0;
          s_nxt.st   = csg_pkg::ST_IDLE;
          case (s_r.svc)
            csg_pkg::SVC_LOGIN: begin
              if (eng_rsp.match && login_role != 2'h0) begin
                s_nxt.role   = csg_pkg::csg_role_e'(login_role);
                s_nxt.result = csg_pkg::RES_OK;
              end else begin
                s_nxt.result = csg_pkg::RES_AUTH_FAIL;
              end
            end
            csg_pkg::SVC_FW_UPDATE:
              s_nxt.result = eng_rsp.match ? csg_pkg::RES_OK : csg_pkg::RES_FW_HMAC;
            csg_pkg::SVC_DIAG_TEST: begin
              pass = s_r.neg ? !eng_rsp.match : eng_rsp.match;
              s_nxt.digest = eng_rsp.digest;
              s_nxt.result = pass ? csg_pkg::RES_OK : csg_pkg::RES_DIAG_FAIL;
            end
            default: s_nxt.result = csg_pkg::RES_OK;
          endcase
        end
      end
      csg_pkg::ST_ZEROIZE: begin
        s_nxt.busy = 1'b0;
        s_nxt.st   = csg_pkg::ST_IDLE;
      end
      csg_pkg::ST_FATAL: s_nxt.busy = 1'b0;
      default: ;
    endcase

    // Command register write
    if (fire_w && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = csg_pkg::AXI_OKAY;
      if (a == csg_pkg::REG_CMD && s_axi_wstrb == 4'hF) begin
        if (s_r.st != csg_pkg::ST_IDLE) begin
          s_nxt.result = csg_pkg::RES_BUSY;
        end else if (!role_ok(d[7:0], s_r.role)) begin
          s_nxt.result = (d[7:0] > csg_pkg::SVC_SHOW_STATUS || d[7:0] == 8'h00)
                         ? csg_pkg::RES_BAD_CMD : csg_pkg::RES_DENIED;
        end else begin
          s_nxt.svc    = d[7:0];
          s_nxt.neg    = d[csg_pkg::CMD_NEG_BIT];
          s_nxt.result = csg_pkg::RES_OK;
          case (d[7:0])
            csg_pkg::SVC_LOGIN: begin
              if (s_r.role != csg_pkg::ROLE_NONE) begin
                s_nxt.result = csg_pkg::RES_LOGGED_IN;
              end else begin
                s_nxt.st = csg_pkg::ST_SERVICE;
                s_nxt.busy = 1'b1;
                s_nxt.req = 1'b1;
              end
            end
            csg_pkg::SVC_LOGOUT: s_nxt.role = csg_pkg::ROLE_NONE;
            csg_pkg::SVC_RESET: begin
              s_nxt.st        = csg_pkg::ST_CRC;
              s_nxt.role      = csg_pkg::ROLE_NONE;
              s_nxt.diag_mode = 1'b0;
              s_nxt.loader    = '0;
              s_nxt.cap       = '0;
              s_nxt.engine    = '0;
              s_nxt.busy      = 1'b1;
              s_nxt.crc_go    = 1'b1;
            end
            csg_pkg::SVC_CONFIGURE: s_nxt.config_word = {8'h00, d[31:8]};
            csg_pkg::SVC_DIAG_TEST: begin
              if (io_message_block_active) begin
                s_nxt.result = csg_pkg::RES_BUSY;
              end else begin
                s_nxt.diag_mode = 1'b1;
                s_nxt.st = csg_pkg::ST_SERVICE;
                s_nxt.busy = 1'b1;
                s_nxt.req = 1'b1;
              end
            end
            csg_pkg::SVC_OP_ZERO_ONE, csg_pkg::SVC_OP_ZERO_ALL: begin
              s_nxt.zero[3] = 1'b1;
              s_nxt.key_valid[3] = 1'b0;
              s_nxt.st = csg_pkg::ST_ZEROIZE;
              s_nxt.busy = 1'b1;
            end
            csg_pkg::SVC_DEK_ZERO, csg_pkg::SVC_KEK_ZERO, csg_pkg::SVC_HMAC_ZERO: begin
              s_nxt.zero = (cmd_svc == csg_pkg::SVC_DEK_ZERO) ? 4'h1
                         : (cmd_svc == csg_pkg::SVC_KEK_ZERO) ? 4'h2 : 4'h4;
              s_nxt.key_valid = s_r.key_valid & ~s_nxt.zero;
              s_nxt.st = csg_pkg::ST_ZEROIZE;
              s_nxt.busy = 1'b1;
            end
            // Keys only arrive wrapped; the unwrap engine does the load
            csg_pkg::SVC_OP_ADD, csg_pkg::SVC_OP_KEY_UPD, csg_pkg::SVC_DEK_UPDATE,
            csg_pkg::SVC_KEK_UPDATE, csg_pkg::SVC_HMAC_SET, csg_pkg::SVC_FW_UPDATE,
            csg_pkg::SVC_ENCRYPT, csg_pkg::SVC_DECRYPT: begin
              s_nxt.st = csg_pkg::ST_SERVICE;
              s_nxt.busy = 1'b1;
              s_nxt.req = 1'b1;
            end
            default: ;
          endcase
        end
      end else if (a != csg_pkg::REG_CMD) begin
        s_nxt.bresp = csg_pkg::AXI_SLVERR;
      end
    end

    // Key validity follows successful loads
    if (s_r.st == csg_pkg::ST_SERVICE && eng_rsp.done && eng_rsp.match) begin
      case (s_r.svc)
        csg_pkg::SVC_DEK_UPDATE: s_nxt.key_valid[0] = 1'b1;
        csg_pkg::SVC_KEK_UPDATE: s_nxt.key_valid[1] = 1'b1;
        csg_pkg::SVC_HMAC_SET:   s_nxt.key_valid[2] = 1'b1;
        csg_pkg::SVC_OP_ADD, csg_pkg::SVC_OP_KEY_UPD: s_nxt.key_valid[3] = 1'b1;
        default: ;
      endcase
    end

    // Read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = csg_pkg::AXI_OKAY;
      case (s_axi_araddr)
        csg_pkg::REG_CMD:      s_nxt.rdata = {24'h000000, s_r.svc};
        csg_pkg::REG_STATUS:   s_nxt.rdata = status_word(s_r);
        csg_pkg::REG_RESULT:   s_nxt.rdata = s_r.result;
        csg_pkg::REG_OPERATOR: s_nxt.rdata = {30'h00000000, s_r.role};
        csg_pkg::REG_CONFIG:   s_nxt.rdata = s_r.config_word;
        csg_pkg::REG_DIGEST:   s_nxt.rdata = s_r.digest;
        csg_pkg::REG_KEYSTATE: s_nxt.rdata = {28'h0000000, s_r.key_valid};
        default: begin
          s_nxt.rdata = '0;
          s_nxt.rresp = csg_pkg::AXI_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r        <= '0;
      s_r.st     <= csg_pkg::ST_CRC;
      s_r.role   <= csg_pkg::ROLE_NONE;
      s_r.busy   <= 1'b1;
      s_r.crc_go <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp  = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata  = s_r.rdata;
  assign s_axi_rresp  = s_r.rresp;
  assign crc_start    = s_r.crc_go;

  always_comb begin
    eng_req.req      = s_r.req;
    eng_req.svc      = (s_r.st == csg_pkg::ST_KAT) ? {5'h00, s_r.kat_idx} : s_r.svc;
    eng_req.negative = (s_r.st == csg_pkg::ST_KAT) ? 1'b0 : s_r.neg;
  end

  // Zeroize index: 0 data key, 1 wrap key, 2 firmware key, 3 operator key
  assign key_zero      = s_r.zero;
  assign key_zero_fill = (s_r.zero[1] || s_r.zero[3]) ? csg_pkg::FILL_BYTE : csg_pkg::ZERO_BYTE;
  // Output blocked in self-test, zeroize, fatal and diagnostic mode
  assign data_out_enable = (s_r.st == csg_pkg::ST_IDLE || s_r.st == csg_pkg::ST_SERVICE)
                        && !s_r.diag_mode;
  assign status_led = {s_r.st == csg_pkg::ST_FATAL, s_r.busy, s_r.role != csg_pkg::ROLE_NONE,
                       s_r.st == csg_pkg::ST_IDLE};

endmodule : csg_gate

// ==== verification/csg_monitor.sv ====
// Checker for csg_gate output relations.
// Assumes a bind into csg_gate; one clock, sync reset.
`timescale 1ns/1ps
module csg_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       crc_start,
  input wire logic       crc_done,
  input wire logic       crc_ok,
  input wire logic [3:0] key_zero,
  input wire logic [7:0] key_zero_fill,
  input wire logic       data_out_enable,
  input wire logic [3:0] status_led
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Self-test span, from reset or restart until ready or fatal
  logic selftest_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || crc_start) begin
      selftest_r <= 1'b1;
    end else if (status_led[0] || status_led[3]) begin
      selftest_r <= 1'b0;
    end
  end
  boot_start_a: assert property ($rose(aresetn) |-> ##[0:2] crc_start) else $error("no crc start");
  fatal_mute_a: assert property (status_led[3] |-> !data_out_enable) else $error("output in fatal");
  selftest_mute_a: assert property ((selftest_r || crc_start) && !status_led[0]
    |-> !data_out_enable) else $error("output in self-test");
  zero_mute_a: assert property (|key_zero |-> !data_out_enable) else $error("output in zeroize");
  fill_ones_a: assert property ((key_zero[1] || key_zero[3])
    |-> key_zero_fill == csg_pkg::FILL_BYTE) else $error("bad ones fill");
  fill_zero_a: assert property ((key_zero[0] || key_zero[2]) && !key_zero[1] && !key_zero[3]
    |-> key_zero_fill == csg_pkg::ZERO_BYTE) else $error("bad zero fill");
  crc_fatal_a: assert property (crc_done && !crc_ok |-> ##[1:3] status_led[3]) else $error("crc not fatal");
  fatal_hold_a: assert property (status_led[3] |=> status_led[3]) else $error("fatal left");
endmodule : csg_monitor

// ==== verification/csg_engine_model.sv ====
// Flash CRC and crypto engine model facing csg_gate.
// Assumes outcomes set by the bench; answers after 2 or 9 cycles.
`timescale 1ns/1ps
module csg_engine_model (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  slow,
  input  wire logic                  crc_good,
  input  wire logic                  eng_good,
  input  wire logic [1:0]            role_in,
  input  wire logic                  crc_start,
  input  wire csg_pkg::csg_eng_req_s eng_req,
  output logic                       crc_done,
  output logic                       crc_ok,
  output csg_pkg::csg_eng_rsp_s      eng_rsp,
  output logic [1:0]                 login_role
);
  logic [3:0]            crc_cnt;
  logic [3:0]            eng_cnt;
  csg_pkg::csg_eng_req_s held;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {crc_cnt, eng_cnt, crc_done, crc_ok, eng_rsp, login_role} <= '0;
    end else begin
      // Qualified lines scramble outside done, so no stale value can be trusted
      {crc_ok, eng_rsp, login_role} <= ~{crc_ok, eng_rsp, login_role};
      crc_done <= 1'h0;
      eng_rsp.done <= 1'h0;
      crc_cnt <= crc_start ? (slow ? 4'h9 : 4'h2) : crc_cnt - 4'(crc_cnt != 4'h0);
      eng_cnt <= eng_req.req ? (slow ? 4'h9 : 4'h2) : eng_cnt - 4'(eng_cnt != 4'h0);
      if (eng_req.req) held <= eng_req;
      if (crc_cnt == 4'h1) begin
        crc_done <= 1'h1;
        crc_ok <= crc_good;
      end
      if (eng_cnt == 4'h1) begin
        eng_rsp.done <= 1'h1;
        eng_rsp.match <= eng_good && !held.negative;
        eng_rsp.digest <= {16'hC0DE, 8'h00, held.svc};
        login_role <= role_in;
      end
    end
  end
endmodule : csg_engine_model

// ==== verification/testbench.sv ====
// Self-checking bench: AXI4-Lite host, engine model, bound checker.
// Assumes the csg_pkg register map and result codes.
`timescale 1ns/1ps
module testbench;
  logic aclk = '0, aresetn = '0, slow = '0, crc_good = '1, eng_good = '1, io_message_block_active = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0, s_axi_bready = '1, s_axi_rready = '1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, key_zero_fill;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF, key_zero, status_led;
  logic [1:0] role_in = '0, rsp, s_axi_bresp, s_axi_rresp, login_role;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic crc_start, crc_done, crc_ok, data_out_enable;
  csg_pkg::csg_eng_req_s eng_req;
  csg_pkg::csg_eng_rsp_s eng_rsp;
  int num_errors = 0, checks_done = 0;
  csg_gate dut (.*);
  csg_engine_model model (.*);
  initial forever #5 aclk = ~aclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Ready is sampled at the falling edge: inputs only move after rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
    do begin
      @(negedge aclk);
      {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end while (!b);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
    do begin
      @(negedge aclk);
      {ar, r, rv, rsp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
    end while (!r);
  endtask : rd
  task automatic poll();
    do rd(csg_pkg::REG_STATUS); while (rv[csg_pkg::ST_BUSY_BIT] !== 1'h0);
  endtask : poll
  task automatic cmd(input csg_pkg::csg_svc_e s, input logic [31:0] e, input logic neg = 1'h0);
    wr(csg_pkg::REG_CMD, 32'(s) | (32'(neg) << csg_pkg::CMD_NEG_BIT));
    poll();
    rd(csg_pkg::REG_RESULT);
    check(rv, e);
  endtask : cmd
  task automatic restart();
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    poll();
  endtask : restart
  task automatic t_boot();
    restart();
    check(rv[3:0], {csg_pkg::CAP_OK, csg_pkg::LOADER_OK});
    check(rv[csg_pkg::ST_READY_BIT], 1'h1);
    rd(8'h3C);
    check(rsp, csg_pkg::AXI_SLVERR);
  endtask : t_boot
  task automatic t_roles();
    cmd(csg_pkg::SVC_ENCRYPT, csg_pkg::RES_DENIED);
    cmd(csg_pkg::SVC_LOGOUT, csg_pkg::RES_OK);
    role_in <= 2'h1;
    cmd(csg_pkg::SVC_LOGIN, csg_pkg::RES_OK);
    cmd(csg_pkg::SVC_LOGIN, csg_pkg::RES_LOGGED_IN);
    cmd(csg_pkg::SVC_ENCRYPT, csg_pkg::RES_DENIED);
    io_message_block_active <= 1'h1;
    cmd(csg_pkg::SVC_DIAG_TEST, csg_pkg::RES_BUSY);
    io_message_block_active <= 1'h0;
    cmd(csg_pkg::SVC_DEK_UPDATE, csg_pkg::RES_OK);
    cmd(csg_pkg::SVC_KEK_UPDATE, csg_pkg::RES_OK);
    cmd(csg_pkg::SVC_KEK_ZERO, csg_pkg::RES_OK);
    rd(csg_pkg::REG_KEYSTATE);
    check(rv, 32'h0000_0001);
    wr(csg_pkg::REG_CMD, 32'h00AB_CD01);
    rd(csg_pkg::REG_CONFIG);
    check(rv, 32'h0000_ABCD);
    cmd(csg_pkg::SVC_DIAG_TEST, csg_pkg::RES_OK, 1'h1);
    rd(csg_pkg::REG_DIGEST);
    check(rv[31:16], 16'hC0DE);
    cmd(csg_pkg::SVC_RESET, csg_pkg::RES_OK);
    cmd(csg_pkg::SVC_LOGOUT, csg_pkg::RES_OK);
    role_in <= 2'h2;
    cmd(csg_pkg::SVC_LOGIN, csg_pkg::RES_OK);
    cmd(csg_pkg::SVC_DIAG_TEST, csg_pkg::RES_DENIED);
    cmd(csg_pkg::SVC_CONFIGURE, csg_pkg::RES_DENIED);
    cmd(csg_pkg::SVC_OP_ZERO_ALL, csg_pkg::RES_OK);
    eng_good <= 1'h0;
    cmd(csg_pkg::SVC_FW_UPDATE, csg_pkg::RES_FW_HMAC);
  endtask : t_roles
  task automatic t_fail();
    slow <= 1'h1;
    crc_good <= 1'h0;
    restart();
    check(rv[csg_pkg::ST_FATAL_BIT], 1'h1);
    check(rv[1:0], csg_pkg::LOADER_FAIL);
    crc_good <= 1'h1;
    restart();
    check(rv[11:2], {csg_pkg::ENG_AES, csg_pkg::CAP_FAIL});
    check(rv[csg_pkg::ST_OUTEN_BIT], 1'h0);
  endtask : t_fail
  initial begin
    t_boot();
    t_roles();
    t_fail();
    tally_and_finish();
  end
  initial begin
    #200us;
    num_errors++;
    tally_and_finish();
  end
endmodule : testbench
bind csg_gate csg_monitor mon (.*);
